// ==== hw/sfp_core.sv ====
// Purpose: SPI command decoder, status register and array read
// Assumes: serial clock at most an eighth of CLK_SYS
// Notes: array is read combinationally through ARR_ADDR/ARR_DATA
module sfp_core (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic S_B_PIN,
    input wire logic C_PIN,
    input wire logic D_PIN,
    input wire logic W_B_PIN,
    output logic Q_O,
    output logic Q_OE,
    output logic [17:0] ARR_ADDR,
    input wire logic [7:0] ARR_DATA
);
    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    logic [3:0] pins_s;
    logic sel_d_r;
    logic c_d_r;
    logic sel;
    logic c_s;
    logic d_s;
    logic w_b_s;

    sfp_sync #(.W(4)) u_sync (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .din({~S_B_PIN, C_PIN, D_PIN, W_B_PIN}),
        .dout(pins_s)
    );

    assign sel = pins_s[3];
    assign c_s = pins_s[2];
    assign d_s = pins_s[1];
    assign w_b_s = pins_s[0];

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            sel_d_r <= 1'b0;
            c_d_r <= 1'b0;
        end else begin
            sel_d_r <= sel;
            c_d_r <= c_s;
        end
    end

    wire cs_fall = sel & ~sel_d_r;
    wire cs_rise = ~sel & sel_d_r;
    wire c_rise = sel & c_s & ~c_d_r;
    wire c_fall = sel & ~c_s & c_d_r;

    // -------------------------------------------------------------
    // frame state
    // -------------------------------------------------------------
    sfp_pkg::sfp_state_t state_r;
    sfp_pkg::sfp_state_t state_nxt;
    logic [6:0] sh_r;
    logic [2:0] bit_r;
    logic [2:0] nb_r;
    logic [7:0] cmd_r;
    logic [23:0] addr_r;
    logic [7:0] osh_r;
    logic wel_r;
    logic status_write_disable_r;
    logic [1:0] bp_r;
    logic busy;
    logic q_r;
    logic oe_r;

    // msb first, sampled on rising serial clock
    wire [7:0] in_byte = {sh_r, d_s};
    wire byte_done = c_rise & (bit_r == sfp_pkg::BIT_LAST);
    wire [2:0] nb_inc = (nb_r == 3'h7) ? nb_r : nb_r + 3'h1;
    // only whole-byte frames may commit writes
    wire on_byte = cs_rise & (bit_r == 3'h0);
    // hardware protect follows pin and bit in either order
    wire hardware_protect_mode = status_write_disable_r & ~w_b_s;

    function automatic logic prot(input logic [1:0] bp,
                                  input logic [1:0] sec);
        logic r;
        r = 1'b0;
        case (bp)
            2'h1: r = (sec == 2'h3);
            2'h2: r = sec[1];
            2'h3: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : prot

    // top six address bits are never decoded
    localparam int ADDR_TOP = sfp_pkg::ADDR_W - 1;
    wire [1:0] sec = addr_r[ADDR_TOP:ADDR_TOP - 1];
    wire area_prot = prot(bp_r, sec);

    // -------------------------------------------------------------
    // status byte
    // -------------------------------------------------------------
    sfp_pkg::sfp_status_t status;
    assign status.status_write_disable = status_write_disable_r;
    assign status.zero = sfp_pkg::SR_ZERO;
    assign status.bp = bp_r;
    assign status.write_enable_latch = wel_r;
    assign status.busy = busy;

    // -------------------------------------------------------------
    // commit decode on deselect
    // -------------------------------------------------------------
    wire go_ok = on_byte & ~busy;
    wire set_write_latch_cmd_go = go_ok & (nb_r == sfp_pkg::NB_CMD)
        & (cmd_r == sfp_pkg::SET_WRITE_LATCH_CMD);
    wire clear_write_latch_cmd_go = go_ok & (nb_r == sfp_pkg::NB_CMD)
        & (cmd_r == sfp_pkg::CLEAR_WRITE_LATCH_CMD);
    // exactly one data byte, latch set, not locked
    wire status_write_cmd_go = go_ok & wel_r & ~hardware_protect_mode
        & (nb_r == sfp_pkg::NB_STATUS_WRITE_CMD)
        & (cmd_r == sfp_pkg::STATUS_WRITE_CMD);
    wire pp_go = go_ok & wel_r & ~area_prot
        & (nb_r >= sfp_pkg::NB_PP_MIN)
        & (cmd_r == sfp_pkg::PAGE_PROGRAM_CMD);
    wire se_go = go_ok & wel_r & ~area_prot
        & (nb_r == sfp_pkg::NB_ADDR)
        & (cmd_r == sfp_pkg::SECTOR_ERASE_CMD);
    wire be_go = go_ok & wel_r & (bp_r == 2'h0)
        & (nb_r == sfp_pkg::NB_CMD)
        & (cmd_r == sfp_pkg::BULK_ERASE_CMD);
    wire cyc_go = status_write_cmd_go | pp_go | se_go | be_go;
    wire [11:0] cyc_len = status_write_cmd_go ? sfp_pkg::WR_CYC
        : pp_go ? sfp_pkg::PP_CYC : sfp_pkg::ERASE_CYC;

    sfp_timer u_timer (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .start(cyc_go),
        .len(cyc_len),
        .busy(busy)
    );

    // -------------------------------------------------------------
    // next state on byte boundaries
    // -------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        if (cs_fall | cs_rise) begin
            state_nxt = sfp_pkg::ST_CMD;
        end else if (byte_done) begin
            case (state_r)
                sfp_pkg::ST_CMD: begin
                    case (in_byte)
                        sfp_pkg::STATUS_READ_CMD:
                            state_nxt = sfp_pkg::ST_SR;
                        sfp_pkg::STATUS_WRITE_CMD:
                            state_nxt = sfp_pkg::ST_DIN;
                        sfp_pkg::ARRAY_READ_CMD,
                        sfp_pkg::PAGE_PROGRAM_CMD,
                        sfp_pkg::SECTOR_ERASE_CMD:
                            state_nxt = sfp_pkg::ST_ADDR;
                        default: state_nxt = sfp_pkg::ST_IGN;
                    endcase
                end
                sfp_pkg::ST_ADDR: begin
                    if (nb_inc == sfp_pkg::NB_ADDR) begin
                        if (cmd_r != sfp_pkg::ARRAY_READ_CMD)
                            state_nxt = sfp_pkg::ST_DIN;
                        else if (busy)
                            state_nxt = sfp_pkg::ST_IGN;
                        else
                            state_nxt = sfp_pkg::ST_RD;
                    end
                end
                sfp_pkg::ST_DIN: state_nxt = sfp_pkg::ST_DIN;
                sfp_pkg::ST_SR: state_nxt = sfp_pkg::ST_SR;
                sfp_pkg::ST_RD: state_nxt = sfp_pkg::ST_RD;
                sfp_pkg::ST_IGN: state_nxt = sfp_pkg::ST_IGN;
                default: state_nxt = sfp_pkg::ST_IGN;
            endcase
        end
    end

    // -------------------------------------------------------------
    // input shifting and counters
    // -------------------------------------------------------------
    wire rd_next = byte_done & (state_r == sfp_pkg::ST_RD);
    wire addr_in = byte_done & (state_r == sfp_pkg::ST_ADDR);

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            state_r <= sfp_pkg::ST_CMD;
            sh_r <= 7'h00;
            bit_r <= 3'h0;
            nb_r <= 3'h0;
            cmd_r <= 8'h00;
            addr_r <= 24'h000000;
        end else begin
            state_r <= state_nxt;
            if (cs_fall) begin
                bit_r <= 3'h0;
                nb_r <= 3'h0;
                cmd_r <= 8'h00;
            end else if (c_rise) begin
                sh_r <= in_byte[6:0];
                bit_r <= bit_r + 3'h1;
                if (byte_done)
                    nb_r <= nb_inc;
                if (byte_done & (state_r == sfp_pkg::ST_CMD))
                    cmd_r <= in_byte;
            end
            if (addr_in)
                addr_r <= {addr_r[15:0], in_byte};
            else if (rd_next)
                addr_r <= {6'h00, addr_r[17:0] + 18'h00001};
        end
    end

    assign ARR_ADDR = addr_r[17:0];

    // whole byte kept: the shifter alone drops the msb of the data byte
    logic [7:0] in_word_r;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B)
            in_word_r <= 8'h00;
        else if (byte_done)
            in_word_r <= in_byte;
    end

    // -------------------------------------------------------------
    // write latch and non-volatile bits
    // -------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            wel_r <= 1'b0;
            status_write_disable_r <= sfp_pkg::STATUS_WRITE_DISABLE_RST;
            bp_r <= sfp_pkg::BP_RST;
        end else begin
            if (set_write_latch_cmd_go)
                wel_r <= 1'b1;
            else if (clear_write_latch_cmd_go | cyc_go)
                wel_r <= 1'b0;
            if (status_write_cmd_go) begin
                // only protect and disable bits are written
                status_write_disable_r <= in_word_r[sfp_pkg::SR_STATUS_WRITE_DISABLE_BIT];
                bp_r <= in_word_r[sfp_pkg::SR_BP_LO +: 2];
            end
        end
    end

    // -------------------------------------------------------------
    // output shifter, changes on falling serial clock
    // -------------------------------------------------------------
    wire out_st = (state_r == sfp_pkg::ST_SR)
        | (state_r == sfp_pkg::ST_RD);
    // status is re-sampled at each byte so busy polling sees progress
    wire [7:0] src = (state_r == sfp_pkg::ST_SR) ? status
        : ARR_DATA;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            q_r <= 1'b0;
            oe_r <= 1'b0;
            osh_r <= 8'h00;
        end else if (~sel | ~out_st) begin
            oe_r <= 1'b0;
            q_r <= 1'b0;
        end else if (c_fall) begin
            oe_r <= 1'b1;
            if (bit_r == 3'h0) begin
                q_r <= src[7];
                osh_r <= {src[6:0], 1'b0};
            end else begin
                q_r <= osh_r[7];
                osh_r <= {osh_r[6:0], 1'b0};
            end
        end
    end

    assign Q_O = q_r;
    assign Q_OE = oe_r;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    sequence status_write_cmd_seen;
        status_write_cmd_go ##1 busy;
    endsequence

    latch_set_a: assert property (set_write_latch_cmd_go |=> wel_r)
        else $error("set-latch command did not set latch");
    latch_clr_a: assert property (clear_write_latch_cmd_go |=> !wel_r)
        else $error("clear-latch command left latch set");
    cycle_gate_a: assert property (cyc_go |-> wel_r ##1 !wel_r)
        else $error("write cycle without latch or latch kept");
    bulk_gate_a: assert property (be_go |-> bp_r == 2'h0)
        else $error("bulk erase with protected sectors");
    busy_run_a: assert property (status_write_cmd_go |-> status_write_cmd_seen ##0 busy[*8])
        else $error("status write did not hold busy");
    hpm_lock_a: assert property (hardware_protect_mode |=> $stable(status_write_disable_r)
        && $stable(bp_r))
        else $error("status changed while locked");
    sr_zero_a: assert property (status[6:4] == 3'h0 &&
        status[0] == busy)
        else $error("status reserved bits or busy wrong");
    rd_wrap_a: assert property (rd_next && addr_r[17:0] == 18'h3FFFF
        |=> addr_r[17:0] == 18'h00000)
        else $error("read address failed to wrap");
    rd_reject_a: assert property (addr_in && busy &&
        cmd_r == sfp_pkg::ARRAY_READ_CMD && nb_inc == sfp_pkg::NB_ADDR
        |=> state_r == sfp_pkg::ST_IGN)
        else $error("read accepted during busy cycle");
    desel_a: assert property (cs_rise |=> ##1 !Q_OE)
        else $error("output still driven after deselect");
endmodule : sfp_core

// ==== hw/sfp_pkg.sv ====
// Purpose: constants and types of the serial flash command logic
// Assumes: 100 MHz system clock, SPI mode 0/3 sampled through syncs
// Notes: shared by the command core and its testbench
// Function
// - set-latch command sets write latch
// - clear-latch command clears write latch
// - latch cleared at reset and write completions; here cleared as the write cycle starts
// - status readable anytime, repeated while clocked
// - busy is one during self-timed cycles
// - latch clear refuses all write commands
// - protect bits kept, written, guard sectors
// - bulk erase only with protect bits zero
// - hardware protect locks status against writes
// - bits 6..4,1,0 unwritable; 6..4 read zero
// - status write needs deselect after byte
// - valid status write starts timed busy cycle
// - disable bit zero allows writes regardless
// - protect mode entered either order, pin exits
// - read takes command and three address bytes
// - top six address bits ignored
// - read address increments and wraps to zero
// - deselect ends read; busy rejects read
// - codes 06h, 04h, 05h
// - codes 01h and 03h
// - write commands need whole-byte clock count
// - protect encoding covers sector quarters
package sfp_pkg;
    // -------------------------------------------------------------
    // command codes
    // -------------------------------------------------------------
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
    localparam logic [7:0] BULK_ERASE_CMD = 8'hC7;
    // -------------------------------------------------------------
    // status layout and reset
    // -------------------------------------------------------------
    localparam int SR_BP_LO = 2;
    localparam int SR_STATUS_WRITE_DISABLE_BIT = 7;
    localparam logic STATUS_WRITE_DISABLE_RST = 1'b0;
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic [2:0] SR_ZERO = 3'h0;
    // -------------------------------------------------------------
    // frame byte counts
    // -------------------------------------------------------------
    localparam logic [2:0] NB_CMD = 3'h1;
    localparam logic [2:0] NB_STATUS_WRITE_CMD = 3'h2;
    localparam logic [2:0] NB_ADDR = 3'h4;
    localparam logic [2:0] NB_PP_MIN = 3'h5;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int ADDR_W = 18;
    // -------------------------------------------------------------
    // self-timed cycle lengths
    // -------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int WR_TIME_NS = 15000;
    localparam int PP_TIME_NS = 5000;
    localparam int ERASE_TIME_NS = 40000;
    localparam logic [11:0] WR_CYC = 12'(WR_TIME_NS / CLK_NS);
    localparam logic [11:0] PP_CYC = 12'(PP_TIME_NS / CLK_NS);
    localparam logic [11:0] ERASE_CYC = 12'(ERASE_TIME_NS / CLK_NS);

    typedef struct packed {
        logic status_write_disable;
        logic [2:0] zero;
        logic [1:0] bp;
        logic write_enable_latch;
        logic busy;
    } sfp_status_t;

    typedef enum logic [2:0] {
        ST_CMD = 3'h0,
        ST_ADDR = 3'h1,
        ST_DIN = 3'h2,
        ST_SR = 3'h3,
        ST_RD = 3'h4,
        ST_IGN = 3'h5
    } sfp_state_t;
endpackage : sfp_pkg

// ==== hw/sfp_sync.sv ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: destination is CLK_SYS
// Notes: first stage feeds only the second
module sfp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : sfp_sync

// ==== hw/sfp_timer.sv ====
// Purpose: self-timed cycle counter behind the busy flag
// Assumes: start is a one-cycle pulse
// Notes: busy rises the cycle after start
module sfp_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [11:0] len,
    output logic busy
);
    logic [11:0] cnt_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= 12'h000;
        end else if (start) begin
            cnt_r <= len;
        end else if (cnt_r != 12'h000) begin
            cnt_r <= cnt_r - 12'h001;
        end
    end

    assign busy = (cnt_r != 12'h000);
endmodule : sfp_timer

// ==== dv/sfp_host_model.sv ====
// Purpose: serial bus master model driving the flash command pins
// Assumes: mode 0 framing, serial clock far below the system clock
// Notes: pins change only just after a system clock rising edge
module sfp_host_model (
    input wire logic clk,
    input wire logic q_o,
    input wire logic q_oe,
    output logic s_b,
    output logic c,
    output logic d
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------
    // pin state
    // ---------------------------------------------------------
    // half period of six cycles leaves margin over the sync delay
    localparam int HALF = 6;
    logic oe_seen;
    logic last_q;

    initial begin
        s_b = 1'b1;
        c = 1'b0;
        d = 1'b1;
        oe_seen = 1'b0;
        last_q = 1'b0;
    end

    // ---------------------------------------------------------
    // framing tasks
    // ---------------------------------------------------------
    task automatic start_frame();
        @(posedge clk) s_b <= 1'b0;
        oe_seen = 1'b0;
        repeat (HALF) @(posedge clk);
    endtask : start_frame

    // released output: take the inverse of the last bit, not a guess
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            @(posedge clk) d <= tx[i];
            repeat (HALF) @(posedge clk);
            last_q = q_oe ? q_o : ~last_q;
            oe_seen = oe_seen | q_oe;
            rx[i] = last_q;
            c <= 1'b1;
            repeat (HALF) @(posedge clk);
            c <= 1'b0;
        end
    endtask : shift

    // clock stands low between frames; data line driven to the inverse of its last bit
    task automatic end_frame();
        repeat (HALF) @(posedge clk);
        s_b <= 1'b1;
        d <= ~d;
        repeat (8) @(posedge clk);
    endtask : end_frame
endmodule : sfp_host_model

// ==== dv/test_serial_flash_status_protect_read.sv ====
// Purpose: self-checking bench of the serial flash command core
// Assumes: host model owns the serial pins, bench owns W and reset
// Notes: array contents come from a fixed address pattern
module test_serial_flash_status_protect_read;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------
    logic CLK_SYS, RST_B, W_B_PIN, S_B_PIN, C_PIN, D_PIN, Q_O, Q_OE;
    logic [17:0] ARR_ADDR;
    logic [7:0] ARR_DATA;
    logic [7:0] s0, s1;
    logic [7:0] rb [3];
    int fail_count, n_compared;

    function automatic logic [7:0] pat(input logic [17:0] a);
        return a[7:0] ^ {6'h00, a[17:16]} ^ 8'hA5;
    endfunction : pat

    assign ARR_DATA = pat(ARR_ADDR);

    sfp_core uut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .S_B_PIN(S_B_PIN),
        .C_PIN(C_PIN), .D_PIN(D_PIN), .W_B_PIN(W_B_PIN), .Q_O(Q_O),
        .Q_OE(Q_OE), .ARR_ADDR(ARR_ADDR), .ARR_DATA(ARR_DATA));

    sfp_host_model host (.clk(CLK_SYS), .q_o(Q_O), .q_oe(Q_OE),
        .s_b(S_B_PIN), .c(C_PIN), .d(D_PIN));

    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    // ---------------------------------------------------------
    // compare and access tasks
    // ---------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic cmd(input logic [7:0] code, input int nb);
        logic [7:0] rx;
        host.start_frame();
        host.shift(code, nb, rx);
        host.end_frame();
    endtask : cmd

    task automatic wr_sr(input logic [7:0] val, input int nb);
        logic [7:0] rx;
        host.start_frame();
        host.shift(sfp_pkg::STATUS_WRITE_CMD, 8, rx);
        host.shift(val, nb, rx);
        host.end_frame();
    endtask : wr_sr

    // two bytes, so a repeated status byte can be compared
    task automatic rd_sr();
        logic [7:0] rx;
        host.start_frame();
        host.shift(sfp_pkg::STATUS_READ_CMD, 8, rx);
        host.shift(8'h00, 8, s0);
        host.shift(8'h00, 8, s1);
        host.end_frame();
    endtask : rd_sr

    // poll busy instead of timing the cycle blindly
    task automatic wait_idle();
        int k;
        k = 0;
        rd_sr();
        while (s0[0] !== 1'b0 && k < 200) begin
            rd_sr();
            k++;
        end
        chk_bit("busy cleared", 1'b0, s0[0]);
    endtask : wait_idle

    task automatic arr_read(input logic [23:0] a);
        logic [7:0] rx;
        host.start_frame();
        host.shift(sfp_pkg::ARRAY_READ_CMD, 8, rx);
        host.shift(a[23:16], 8, rx);
        host.shift(a[15:8], 8, rx);
        host.shift(a[7:0], 8, rx);
        for (int i = 0; i < 3; i++) begin
            host.shift(8'h00, 8, rb[i]);
        end
        host.end_frame();
    endtask : arr_read

    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (60000) @(posedge CLK_SYS);
        fail_count++;
        end_sim();
    end

    // ---------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------
    initial begin
        fail_count = 0;
        n_compared = 0;
        RST_B = 1'b0;
        W_B_PIN = 1'b1;
        repeat (5) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        rd_sr();
        chk("status at reset", 8'h00, s0);
        cmd(sfp_pkg::SET_WRITE_LATCH_CMD, 8);
        rd_sr();
        chk("latch set", 8'h02, s0);
        cmd(sfp_pkg::CLEAR_WRITE_LATCH_CMD, 8);
        rd_sr();
        chk("latch cleared", 8'h00, s0);
        cmd(sfp_pkg::SET_WRITE_LATCH_CMD, 7);
        rd_sr();
        chk("short frame", 8'h00, s0);
        wr_sr(8'h8C, 8);
        wait_idle();
        chk("write without latch", 8'h00, s0);
        $display("test latch done");
        cmd(sfp_pkg::SET_WRITE_LATCH_CMD, 8);
        wr_sr(8'hFF, 8);
        rd_sr();
        chk("status during write", 8'h8D, s0);
        chk("status repeated", 8'h8D, s1);
        arr_read(24'h000010);
        chk_bit("read while busy", 1'b0, host.oe_seen);
        wait_idle();
        chk("status written", 8'h8C, s0);
        $display("test status write done");
        W_B_PIN <= 1'b0;
        cmd(sfp_pkg::SET_WRITE_LATCH_CMD, 8);
        wr_sr(8'h00, 8);
        wait_idle();
        chk("hardware protect", 8'h8E, s0);
        W_B_PIN <= 1'b1;
        wr_sr(8'h00, 8);
        wait_idle();
        chk("protect left", 8'h00, s0);
        W_B_PIN <= 1'b0;
        cmd(sfp_pkg::SET_WRITE_LATCH_CMD, 8);
        wr_sr(8'h0C, 8);
        wait_idle();
        chk("disable clear, pin low", 8'h0C, s0);
        cmd(sfp_pkg::SET_WRITE_LATCH_CMD, 8);
        cmd(sfp_pkg::BULK_ERASE_CMD, 8);
        rd_sr();
        chk("bulk refused", 8'h0E, s0);
        wr_sr(8'h00, 7);
        rd_sr();
        chk("unfinished write", 8'h0E, s0);
        wr_sr(8'h00, 8);
        wait_idle();
        chk("protect cleared", 8'h00, s0);
        cmd(sfp_pkg::SET_WRITE_LATCH_CMD, 8);
        cmd(sfp_pkg::BULK_ERASE_CMD, 8);
        rd_sr();
        chk("bulk accepted", 8'h01, s0);
        wait_idle();
        W_B_PIN <= 1'b1;
        $display("test protection done");
        arr_read(24'hFFFFFE);
        chk("first byte", pat(18'h3FFFE), rb[0]);
        chk("second byte", pat(18'h3FFFF), rb[1]);
        chk("wrapped byte", pat(18'h00000), rb[2]);
        chk_bit("output released", 1'b0, Q_OE);
        $display("test array read done");
        end_sim();
    end
endmodule : test_serial_flash_status_protect_read
